// ==== logic/rrio_handshake.sv ====
// remote control I/O handshake: pin mapping, command decode, slot and status state
// assumes pins from an outside sequencer, core status on ref_clk, plain register port
// Function
// - every function input except halt and every function output has a configurable signal number, inputs first
// - teaching mode status output follows controller teaching mode
// - automatic mode status output follows controller automatic mode
// - remote mode status output follows controller remote mode
// - power-on complete asserted when inputs accepted; sequencer waits for it
// - held permit input allows automatic operation, mirrored on an output
// - start edge starts all slots; operating output while any slot runs
// - held halt input stops all slots into wait; its signal number fixed at 0
// - secondary halt behaves as main halt, signal number reassignable
// - wait output asserted while any slot is stopped by a halt
// - program reset edge clears wait; output flags program selection possible
// - fault clear edge clears error; error output held while error exists
// - cycle stop edge requests cycle stop; output while in progress
// - held servo disable turns servos off; its state is echoed
// - servo enable edge turns servos on; servo-on state output
// - held rights input requests operation rights; output while rights valid
// - machine lock edge toggles lock; lock state output
// - evasion return edge requests return; output while it is in progress
// - general output clear edge clears general outputs; no paired output
// - emergency stop output asserted once an emergency stop has occurred
// - per-slot start edges start own slot, each slot has operating output
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rrio_defs.svh"

module rrio_handshake (
    input  wire logic                      ref_clk,       // 40 MHz clock
    input  wire logic                      rst_n,         // async reset, active low
    input  wire logic [`RRIO_PINS-1:0]     in_pins,       // sequencer input pins
    output var  logic [`RRIO_PINS-1:0]     out_pins,      // sequencer output pins
    input  wire rrio_pkg::rrio_core_t      core,          // controller status
    input  wire rrio_pkg::rrio_bus_req_t   bus,           // register request
    output var  logic [31:0]               rdata,         // read data, next cycle
    output var  logic [`RRIO_SLOTS-1:0]    slot_running,  // slots in run
    output var  logic                      servo_on,      // servo power state
    output var  logic                      machine_lock,  // lock state
    output var  logic                      evasion_active,// evasion return busy
    output var  logic                      gp_out_clear   // clear pulse to general outputs
);

    localparam int NI = `RRIO_IN_FUNCS;
    localparam int NO = `RRIO_OUT_FUNCS;
    localparam int NS = `RRIO_SLOTS;

    logic [`RRIO_PINS-1:0] pins;
    logic [6:0]            in_map  [NI];
    logic [6:0]            out_map [NO];
    rrio_pkg::rrio_slot_t  slot_st [NS];
    rrio_pkg::rrio_slot_t  next_st [NS];
    logic [NI-1:0]         in_lvl;
    logic [NI-1:0]         in_prev;
    logic [NI-1:0]         in_rise;
    logic [NS-1:0]         sl_lvl;
    logic [NS-1:0]         sl_prev;
    logic [NS-1:0]         sl_rise;
    logic [NS-1:0]         run_vec;
    logic [NS-1:0]         wait_vec;
    logic [NS-1:0]         next_run;
    logic [NO-2:0]         out_lvl;
    logic [`RRIO_PINS-1:0] next_out_pins;
    logic [5:0]            sl_pin   [NS];
    logic [4:0]            rdy_cnt;
    logic                  ready;
    logic                  cycle_flag;
    logic                  error_flag;
    logic                  emg_flag;

    rrio_sync3 #(
        .W       (`RRIO_PINS)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin_in  (in_pins),
        .stable  (pins)
    );

    // function input selection; halt ignores its map entry
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_in
            if (gi == `RRIO_FI_HALT) begin : g_fix
                assign in_lvl[gi] = pins[`RRIO_HALT_PIN];
            end else begin : g_map
                assign in_lvl[gi] = in_map[gi][`RRIO_MAP_EN] & pins[in_map[gi][5:0]];
            end
        end
        for (gi = 0; gi < NS; gi++) begin : g_sl
            assign sl_pin[gi]   = in_map[`RRIO_FI_SLOT_BASE][5:0] + 6'(gi);
            assign sl_lvl[gi]   = in_map[`RRIO_FI_SLOT_BASE][`RRIO_MAP_EN] & pins[sl_pin[gi]];
            assign run_vec[gi]  = (slot_st[gi] == rrio_pkg::RRIO_SLOT_RUN);
            assign wait_vec[gi] = (slot_st[gi] == rrio_pkg::RRIO_SLOT_WAIT);
        end
    endgenerate

    assign in_rise = in_lvl & ~in_prev;
    assign sl_rise = sl_lvl & ~sl_prev;

    // command qualification
    wire remote    = (core.mode == rrio_pkg::RRIO_MODE_REMOTE);
    wire rights_ok = ready & remote & in_lvl[`RRIO_FI_RIGHTS];
    wire permit    = in_lvl[`RRIO_FI_PERMIT];
    wire halt_lvl  = in_lvl[`RRIO_FI_HALT] | in_lvl[`RRIO_FI_SEC_HALT];
    wire any_run   = |run_vec;
    wire start_ok  = rights_ok & permit & servo_on & ~halt_lvl & ~cycle_flag
                   & ~error_flag & ~emg_flag;
    wire start_all = start_ok & in_rise[`RRIO_FI_START];
    wire prg_reset = rights_ok & in_rise[`RRIO_FI_PRG_RST];
    wire fault_clr = ready & in_rise[`RRIO_FI_FAULT_CLR];
    wire cyc_req   = rights_ok & in_rise[`RRIO_FI_CYCLE] & any_run;
    wire srv_dis   = in_lvl[`RRIO_FI_SRV_DIS];
    wire srv_req   = rights_ok & in_rise[`RRIO_FI_SRV_EN] & ~emg_flag;
    wire lock_req  = rights_ok & in_rise[`RRIO_FI_MLOCK] & ~any_run;
    wire eva_req   = rights_ok & in_rise[`RRIO_FI_EVASION] & servo_on & ~any_run;
    wire gout_req  = rights_ok & in_rise[`RRIO_FI_GOUT_CLR];

    // slot state: halt wins over done, emergency wins over everything except a start from idle
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            next_st[s] = slot_st[s];
            case (slot_st[s])
                rrio_pkg::RRIO_SLOT_IDLE: begin
                    if (start_all || (start_ok && sl_rise[s]))
                        next_st[s] = rrio_pkg::RRIO_SLOT_RUN;
                end
                rrio_pkg::RRIO_SLOT_RUN: begin
                    if (core.emg_event)
                        next_st[s] = rrio_pkg::RRIO_SLOT_IDLE;
                    else if (halt_lvl)
                        next_st[s] = rrio_pkg::RRIO_SLOT_WAIT;
                    else if (core.slot_done[s])
                        next_st[s] = rrio_pkg::RRIO_SLOT_IDLE;
                end
                rrio_pkg::RRIO_SLOT_WAIT: begin
                    if (core.emg_event || prg_reset)
                        next_st[s] = rrio_pkg::RRIO_SLOT_IDLE;
                    else if (start_all || (start_ok && sl_rise[s]))
                        next_st[s] = rrio_pkg::RRIO_SLOT_RUN;
                end
                default: next_st[s] = rrio_pkg::RRIO_SLOT_IDLE;
            endcase
            next_run[s] = (next_st[s] == rrio_pkg::RRIO_SLOT_RUN);
        end
    end

    // status levels presented on mapped output pins
    assign out_lvl[`RRIO_FO_TEACH]   = (core.mode == rrio_pkg::RRIO_MODE_TEACH);
    assign out_lvl[`RRIO_FO_AUTO]    = (core.mode == rrio_pkg::RRIO_MODE_AUTO);
    assign out_lvl[`RRIO_FO_REMOTE]  = remote;
    assign out_lvl[`RRIO_FO_READY]   = ready;
    assign out_lvl[`RRIO_FO_PERMIT]  = permit;
    assign out_lvl[`RRIO_FO_OPER]    = any_run;
    assign out_lvl[`RRIO_FO_WAIT]    = |wait_vec;
    assign out_lvl[`RRIO_FO_PRG_SEL] = ~any_run & ~(|wait_vec);
    assign out_lvl[`RRIO_FO_ERROR]   = error_flag;
    assign out_lvl[`RRIO_FO_CYCLE]   = cycle_flag;
    assign out_lvl[`RRIO_FO_SRV_DIS] = srv_dis;
    assign out_lvl[`RRIO_FO_SRV_ON]  = servo_on;
    assign out_lvl[`RRIO_FO_RIGHTS]  = rights_ok;
    assign out_lvl[`RRIO_FO_MLOCK]   = machine_lock;
    assign out_lvl[`RRIO_FO_EVASION] = evasion_active;
    assign out_lvl[`RRIO_FO_EMG]     = emg_flag;

    // two functions on one pin are ORed rather than refused
    always_comb begin
        next_out_pins = '0;
        for (int f = 0; f < NO - 1; f++) begin
            if (out_map[f][`RRIO_MAP_EN])
                next_out_pins[out_map[f][5:0]] = next_out_pins[out_map[f][5:0]] | out_lvl[f];
        end
        for (int s = 0; s < NS; s++) begin
            if (out_map[`RRIO_FO_SLOT_BASE][`RRIO_MAP_EN])
                next_out_pins[6'(out_map[`RRIO_FO_SLOT_BASE][5:0] + 6'(s))] =
                    next_out_pins[6'(out_map[`RRIO_FO_SLOT_BASE][5:0] + 6'(s))] | run_vec[s];
        end
    end

    // register decode
    wire [3:0]  in_idx  = bus.addr[5:2];
    wire [4:0]  out_idx = bus.addr[6:2];
    wire        in_hit  = (bus.addr[7:6] == 2'h0) && (in_idx < 4'(NI)) && (bus.addr[1:0] == 2'h0);
    wire        out_hit = bus.addr[7] && (out_idx < 5'(NO)) && (bus.addr[1:0] == 2'h0);
    wire [7:0]  status  = {emg_flag, error_flag, evasion_active, machine_lock,
                           servo_on, cycle_flag, rights_ok, ready};
    wire [31:0] next_rdata =
        !bus.rd                           ? 32'h0 :
        in_hit  ? (in_idx == 4'(`RRIO_FI_HALT) ? {25'h0, 1'b1, `RRIO_HALT_PIN}
                                               : {25'h0, in_map[in_idx]}) :
        out_hit                           ? {25'h0, out_map[out_idx]} :
        (bus.addr == `RRIO_STATUS)        ? {24'h0, status} :
        (bus.addr == `RRIO_SLOT_RUN)      ? run_vec :
        (bus.addr == `RRIO_SLOT_WAIT)     ? wait_vec : 32'h0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int f = 0; f < NI; f++)
                in_map[f] <= (f == `RRIO_FI_SLOT_BASE) ? {1'b1, `RRIO_SLOT_IN_RST}
                                                       : {1'b1, 6'(f + 1)};
            for (int f = 0; f < NO; f++)
                out_map[f] <= (f == `RRIO_FO_SLOT_BASE) ? {1'b1, `RRIO_SLOT_OUT_RST}
                                                        : {1'b1, 6'(f)};
            rdata <= 32'h0;
        end else begin
            if (bus.wr && in_hit && in_idx != 4'(`RRIO_FI_HALT))
                in_map[in_idx] <= bus.wdata[6:0];
            if (bus.wr && out_hit)
                out_map[out_idx] <= bus.wdata[6:0];
            rdata <= next_rdata;
        end
    end

    // power-on settle, then ready while the controller core is up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_cnt <= 5'h0;
            ready   <= 1'b0;
        end else begin
            if (rdy_cnt != 5'(`RRIO_READY_CYCLES))
                rdy_cnt <= rdy_cnt + 5'h1;
            ready <= (rdy_cnt == 5'(`RRIO_READY_CYCLES)) & core.ready;
        end
    end

    // sticky flags: a setting event wins over a clear in the same cycle, except servo_on, where disable and emergency win
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_prev        <= '0;
            sl_prev        <= '0;
            cycle_flag     <= 1'b0;
            error_flag     <= 1'b0;
            emg_flag       <= 1'b0;
            servo_on       <= 1'b0;
            machine_lock   <= 1'b0;
            evasion_active <= 1'b0;
            gp_out_clear   <= 1'b0;
        end else begin
            in_prev        <= in_lvl;
            sl_prev        <= sl_lvl;
            cycle_flag     <= cyc_req | (cycle_flag & any_run);
            error_flag     <= core.error_event | (error_flag & ~fault_clr);
            emg_flag       <= core.emg_event | (emg_flag & ~fault_clr);
            servo_on       <= ~srv_dis & ~core.emg_event & (servo_on | srv_req);
            machine_lock   <= machine_lock ^ lock_req;
            evasion_active <= eva_req | (evasion_active & ~core.evasion_done);
            gp_out_clear   <= gout_req;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < NS; s++)
                slot_st[s] <= rrio_pkg::RRIO_SLOT_IDLE;
            slot_running <= '0;
            out_pins     <= '0;
        end else begin
            slot_st      <= next_st;
            slot_running <= next_run;
            out_pins     <= next_out_pins;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // an emergency in the halt cycle idles the slots instead of parking them
    sequence halt_held;
        halt_lvl && any_run && !core.emg_event;
    endsequence

    sequence slots_stopped;
        ##1 (slot_running == '0) && out_lvl[`RRIO_FO_WAIT];
    endsequence

    AST_HALT_STOPS: assert property (halt_held |-> slots_stopped)
        else $error("halt did not stop running slots");
    AST_START_ALL: assert property (start_all && !halt_lvl && !core.emg_event && !prg_reset
        && core.slot_done == '0 |=> slot_running == '1)
        else $error("start did not run all slots");
    AST_SLOT_START: assert property (start_ok && sl_rise[31] && !core.emg_event && !prg_reset
        && !core.slot_done[31] |=> slot_running[31])
        else $error("slot start edge ignored");
    AST_PRG_RESET: assert property (prg_reset && !halt_lvl && !core.emg_event
        |=> wait_vec == '0)
        else $error("program reset left a slot waiting");
    AST_ERROR_HOLD: assert property (core.error_event
        |=> error_flag ##1 (error_flag || $past(fault_clr)))
        else $error("error flag dropped without clear");
    AST_SERVO_OFF: assert property (srv_dis |=> !servo_on)
        else $error("servo on while disable held");
    AST_SERVO_ON: assert property (srv_req && !srv_dis && !core.emg_event
        |=> servo_on)
        else $error("servo enable edge ignored");
    AST_LOCK_TOGGLE: assert property (lock_req |=> machine_lock != $past(machine_lock))
        else $error("machine lock did not toggle");
    AST_READY_WAIT: assert property (rdy_cnt < 5'(`RRIO_READY_CYCLES) |-> !ready)
        else $error("ready before settle time");
    AST_TEACH_PIN: assert property (!bus.wr && out_map[`RRIO_FO_TEACH] == 7'h40
        ##1 out_map[`RRIO_FO_AUTO][5:0] != 6'h0 && out_map[`RRIO_FO_REMOTE][5:0] != 6'h0
        |-> out_pins[0] == $past(core.mode == rrio_pkg::RRIO_MODE_TEACH))
        else $error("teaching mode pin wrong");
    AST_NO_RIGHTS: assert property (!rights_ok
        |=> (slot_running & ~$past(slot_running)) == '0)
        else $error("slot started without rights");
    AST_EVASION: assert property (eva_req ##1 !core.evasion_done |=> evasion_active)
        else $error("evasion return not reported");

endmodule : rrio_handshake

`default_nettype wire

// ==== shared/rrio_defs.svh ====
// constants of the remote I/O handshake block: offsets, field positions, reset values, timing
// assumes inclusion by bare name from any design file
`ifndef RRIO_DEFS_SVH
`define RRIO_DEFS_SVH

`define RRIO_PINS          64
`define RRIO_SLOTS         32
`define RRIO_IN_FUNCS      14
`define RRIO_OUT_FUNCS     17
// map entry: bit 6 enables the assignment, bits 5:0 hold the signal number
`define RRIO_MAP_EN        6
`define RRIO_HALT_PIN      6'h00
`define RRIO_SLOT_IN_RST   6'h20
`define RRIO_SLOT_OUT_RST  6'h20
// input function positions
`define RRIO_FI_PERMIT     0
`define RRIO_FI_START      1
`define RRIO_FI_HALT       2
`define RRIO_FI_SEC_HALT   3
`define RRIO_FI_PRG_RST    4
`define RRIO_FI_FAULT_CLR  5
`define RRIO_FI_CYCLE      6
`define RRIO_FI_SRV_DIS    7
`define RRIO_FI_SRV_EN     8
`define RRIO_FI_RIGHTS     9
`define RRIO_FI_MLOCK      10
`define RRIO_FI_EVASION    11
`define RRIO_FI_GOUT_CLR   12
`define RRIO_FI_SLOT_BASE  13
// output function positions
`define RRIO_FO_TEACH      0
`define RRIO_FO_AUTO       1
`define RRIO_FO_REMOTE     2
`define RRIO_FO_READY      3
`define RRIO_FO_PERMIT     4
`define RRIO_FO_OPER       5
`define RRIO_FO_WAIT       6
`define RRIO_FO_PRG_SEL    7
`define RRIO_FO_ERROR      8
`define RRIO_FO_CYCLE      9
`define RRIO_FO_SRV_DIS    10
`define RRIO_FO_SRV_ON     11
`define RRIO_FO_RIGHTS     12
`define RRIO_FO_MLOCK      13
`define RRIO_FO_EVASION    14
`define RRIO_FO_EMG        15
`define RRIO_FO_SLOT_BASE  16
// register byte offsets
`define RRIO_IN_MAP_BASE   8'h00
`define RRIO_STATUS        8'h40
`define RRIO_SLOT_RUN      8'h44
`define RRIO_SLOT_WAIT     8'h48
`define RRIO_OUT_MAP_BASE  8'h80
// status register bit positions
`define RRIO_ST_READY      0
`define RRIO_ST_RIGHTS     1
`define RRIO_ST_CYCLE      2
`define RRIO_ST_SRV_ON     3
`define RRIO_ST_MLOCK      4
`define RRIO_ST_EVASION    5
`define RRIO_ST_ERROR      6
`define RRIO_ST_EMG        7
// power-on settle time in ns, and its cycle count at 25 ns per cycle
`define RRIO_READY_NS      400
`define RRIO_CLK_NS        25
`define RRIO_READY_CYCLES  ((`RRIO_READY_NS + `RRIO_CLK_NS - 1) / `RRIO_CLK_NS)

`endif

// ==== shared/rrio_pkg.sv ====
// types of the remote I/O handshake block
// assumes rrio_defs.svh for widths
`include "rrio_defs.svh"

package rrio_pkg;

    typedef enum logic [1:0] {
        RRIO_MODE_TEACH,
        RRIO_MODE_AUTO,
        RRIO_MODE_REMOTE
    } rrio_mode_t;

    typedef enum logic [1:0] {
        RRIO_SLOT_IDLE,
        RRIO_SLOT_RUN,
        RRIO_SLOT_WAIT
    } rrio_slot_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rrio_bus_req_t;

    typedef struct packed {
        rrio_mode_t              mode;
        logic                    ready;
        logic                    error_event;
        logic                    emg_event;
        logic                    evasion_done;
        logic [`RRIO_SLOTS-1:0]  slot_done;
    } rrio_core_t;

endpackage : rrio_pkg

// ==== logic/rrio_sync3.sv ====
// three-stage pin synchroniser with agreement filter
// assumes pins asynchronous to ref_clk; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module rrio_sync3 #(
    parameter int W = 64
) (
    input  wire logic         ref_clk,  // block clock
    input  wire logic         rst_n,    // async reset, active low
    input  wire logic [W-1:0] pin_in,   // raw pins
    output var  logic [W-1:0] stable    // filtered level
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] agree;

    // stage1 feeds stage2 only
    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            stable <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= (stage2 & agree) | (stable & ~agree);
        end
    end

endmodule : rrio_sync3

`default_nettype wire

// ==== bench/rrio_plc_model.sv ====
// sequencer model: drives the command pins, watches the status pins
// assumes pins taken by the block on ref_clk; changes land just after rising edges
`timescale 1ns/1ps
`default_nettype none
`include "rrio_defs.svh"
module rrio_plc_model (
    input  wire logic [`RRIO_PINS-1:0] out_pins, // status pins from the block
    input  wire logic                  ref_clk,  // block clock
    output var  logic [`RRIO_PINS-1:0] in_pins   // command pins to the block
);
    initial in_pins = '0;
    // level commands stay as set until changed again
    task automatic set_pin(input int p, input logic v);
        @(posedge ref_clk);
        in_pins[p] <= v;
    endtask : set_pin
    // high long enough to pass the filter, low long enough to re-arm the edge
    task automatic pulse_pin(input int p);
        set_pin(p, 1'b1);
        repeat (6) @(posedge ref_clk);
        in_pins[p] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : pulse_pin
    // no command goes out before the block says it can take them
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(negedge ref_clk);
            ok = (out_pins[`RRIO_FO_READY] === 1'b1);
        end
    endtask : wait_ready
endmodule : rrio_plc_model
`default_nettype wire

// ==== bench/tb_robot_remote_io_handshake.sv ====
// self-checking bench for the remote I/O handshake: pins, status pins, registers
// assumes default signal maps after reset and the sequencer model on the pins
`timescale 1ns/1ps
`default_nettype none
`include "rrio_defs.svh"
module tb_robot_remote_io_handshake;
    logic                    ref_clk = 1'b0;
    logic                    rst_n;
    logic [`RRIO_PINS-1:0]   in_pins;
    logic [`RRIO_PINS-1:0]   out_pins;
    rrio_pkg::rrio_core_t    core;
    rrio_pkg::rrio_bus_req_t bus;
    logic [31:0]             rdata;
    logic [31:0]             slot_running;
    logic [31:0]             rd_val;
    logic                    servo_on, machine_lock, evasion_active, gp_out_clear, ok;
    int                      error_cnt = 0;
    int                      n_tests   = 0;
    int                      gp_cnt    = 0;
    always #12.5 ref_clk = ~ref_clk;
    rrio_handshake uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .in_pins(in_pins), .out_pins(out_pins),
        .core(core), .bus(bus), .rdata(rdata), .slot_running(slot_running),
        .servo_on(servo_on), .machine_lock(machine_lock),
        .evasion_active(evasion_active), .gp_out_clear(gp_out_clear));
    rrio_plc_model plc (.out_pins(out_pins), .ref_clk(ref_clk), .in_pins(in_pins));
    always @(negedge ref_clk) if (gp_out_clear === 1'b1) gp_cnt++;
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32
    // pin to status pin takes 5-6 cycles; 8 leaves margin, then step off the edge
    task automatic settle;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask : reg_rd
    // k: 0 error, 1 emergency, 2 evasion done, 3+i slot i done
    task automatic core_pulse(input int k);
        @(posedge ref_clk);
        case (k)
            0: core.error_event <= 1'b1;
            1: core.emg_event <= 1'b1;
            2: core.evasion_done <= 1'b1;
            default: core.slot_done[k-3] <= 1'b1;
        endcase
        @(posedge ref_clk);
        core.error_event  <= 1'b0;
        core.emg_event    <= 1'b0;
        core.evasion_done <= 1'b0;
        core.slot_done    <= '0;
    endtask : core_pulse
    task automatic test_end(input string name);
        $display("test %s done, mismatches %0d", name, error_cnt);
    endtask : test_end
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        rst_n      = 1'b0;
        bus        = '0;
        core       = '0;
        core.ready = 1'b1;
        core.mode  = rrio_pkg::RRIO_MODE_REMOTE;
        repeat (12) @(posedge ref_clk);
        chk32("out lo in reset", 32'h0, out_pins[31:0]);
        chk32("out hi in reset", 32'h0, out_pins[63:32]);
        rst_n <= 1'b1;
        plc.wait_ready(ok);
        chk1("ready pin", 1'b1, ok);
        plc.set_pin(10, 1'b1);
        plc.set_pin(1, 1'b1);
        plc.pulse_pin(9);
        settle();
        chk1("rights pin", 1'b1, out_pins[12]);
        chk1("permit pin", 1'b1, out_pins[4]);
        chk1("servo_on", 1'b1, out_pins[11] & servo_on);
        reg_rd(8'h40);
        chk32("status", 32'h0000000B, rd_val);
        reg_wr(8'hB0, 32'h00000068);
        settle();
        chk1("moved rights pin", 1'b1, out_pins[40]);
        reg_wr(8'hB0, 32'h0000004C);
        test_end("power up, rights, servo");
        plc.pulse_pin(2);
        settle();
        chk32("running", 32'hFFFFFFFF, slot_running);
        chk1("oper pin", 1'b1, out_pins[5]);
        plc.set_pin(0, 1'b1);
        settle();
        chk1("wait pin", 1'b1, out_pins[6]);
        chk32("running", 32'h0, slot_running);
        reg_rd(8'h48);
        chk32("waiting", 32'hFFFFFFFF, rd_val);
        plc.set_pin(0, 1'b0);
        plc.pulse_pin(5);
        settle();
        chk1("wait pin", 1'b0, out_pins[6]);
        chk1("select pin", 1'b1, out_pins[7]);
        test_end("start, halt, program reset");
        // the halt entry must ignore this move to pin 25
        reg_wr(8'h08, 32'h00000059);
        reg_wr(8'h0C, 32'h00000054);
        reg_rd(8'h0C);
        chk32("second halt map", 32'h00000054, rd_val);
        plc.pulse_pin(2);
        plc.set_pin(25, 1'b1);
        settle();
        chk32("running", 32'hFFFFFFFF, slot_running);
        plc.set_pin(25, 1'b0);
        plc.set_pin(20, 1'b1);
        settle();
        chk1("wait pin", 1'b1, out_pins[6]);
        plc.set_pin(20, 1'b0);
        plc.pulse_pin(5);
        plc.pulse_pin(63);
        settle();
        chk32("running", 32'h80000000, slot_running);
        chk1("slot 31 pin", 1'b1, out_pins[63]);
        reg_rd(8'h44);
        chk32("run reg", 32'h80000000, rd_val);
        plc.pulse_pin(7);
        settle();
        chk1("cycle pin", 1'b1, out_pins[9]);
        core_pulse(34);
        settle();
        chk1("cycle pin", 1'b0, out_pins[9]);
        chk32("running", 32'h0, slot_running);
        test_end("maps, slot, cycle stop");
        for (int i = 0; i < 2; i++) begin
            plc.pulse_pin(11);
            settle();
            chk32("lock", (i == 0) ? 32'h3 : 32'h0, {30'h0, machine_lock, out_pins[13]});
        end
        plc.pulse_pin(12);
        settle();
        chk1("evasion", 1'b1, evasion_active & out_pins[14]);
        core_pulse(2);
        settle();
        chk1("evasion", 1'b0, evasion_active);
        gp_cnt = 0;
        plc.pulse_pin(13);
        settle();
        chk32("clear pulses", 32'h1, 32'(gp_cnt));
        plc.set_pin(8, 1'b1);
        settle();
        chk1("servo_on", 1'b0, servo_on);
        chk1("servo off pin", 1'b1, out_pins[10]);
        plc.set_pin(8, 1'b0);
        core_pulse(0);
        core_pulse(1);
        settle();
        chk1("error pin", 1'b1, out_pins[8]);
        chk1("emergency pin", 1'b1, out_pins[15]);
        plc.pulse_pin(6);
        settle();
        chk32("error pins", 32'h0, {30'h0, out_pins[15], out_pins[8]});
        reg_rd(8'hF0);
        chk32("unmapped", 32'h0, rd_val);
        test_end("lock, evasion, clear, faults");
        for (int m = 0; m < 3; m++) begin
            @(posedge ref_clk);
            core.mode <= rrio_pkg::rrio_mode_t'(m);
            settle();
            chk32("mode pins", 32'(1 << m), {29'h0, out_pins[2:0]});
        end
        test_end("modes");
        // the ready pin must follow the controller core once settled
        @(posedge ref_clk);
        core.ready <= 1'b0;
        settle();
        chk1("ready pin", 1'b0, out_pins[3]);
        @(posedge ref_clk);
        core.ready <= 1'b1;
        settle();
        chk1("ready pin", 1'b1, out_pins[3]);
        test_end("core ready");
        print_verdict();
    end
    // the sequence needs about 400 cycles; fifty times that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : tb_robot_remote_io_handshake
`default_nettype wire
